/* rtl/sdec_drop_capture.v */
// Drop event capture status with read-clear and interrupt masking.
// Assumes the switch engine presents one-cycle drop pulses with port
// and qualifying condition flags; the reason is derived here; Avalon-MM slave for software.
// What this block does
// - Two capture sets, A filled first and then B, each hold one drop record.
// - Mask bit, reset one, blocks the interrupt; status still updates.
// - Set B reason code sits in bits 14 to 11.
// - Set A reason code sits in bits 7 to 4, same code table.
// - Code 0000: tagged-only admission on, frame untagged or priority tagged.
// - Code 0001: unknown destination, membership check, non-member source.
// - Code 0010: known destination, source port not forwarding.
// - Code 0011: known destination, destination port not forwarding.
// - Code 0100: known destination, destination not VLAN member.
// - Code 0101: known destination, source not member, no admission.
// - Code 0110: unknown-unicast discard and unicast destination missing.
// - Code 0111: multicast filtering and multicast destination missing.
// - Code 1000: broadcast discarded over the rate limit.
// - Code 1001: unknown or broadcast destination, source not forwarding.
// - Code 1010: known destination resolves to the receiving port.
// - Code 1011: lookup entry has its filter flag set.
// - Code 1110: all-ones VLAN identifier; 1100, 1101, 1111 never made.
// - Port in bits 10:9 (B) and 3:2 (A); 11 never produced.
// - Set B valid at bit 8 only with a meaningful record.
// - Set A valid at bit 1 only with a meaningful record.
// - Pending at bit 0 once any drop has been recorded.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "sdec_map.vh"

module sdec_drop_capture #(
  parameter ADDR_W = 16
) (
  input  wire              ref_clk,
  input  wire              rst_b,
  // Register bus
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output wire              waitrequest,
  output reg  [31:0]       readdata,
  output reg  [1:0]        response,
  // Drop record from the forwarding engine
  input  wire              dropEvent,
  input  wire [1:0]        dropPort,
  // Conditions, sampled together with the drop pulse
  input  wire              taggedOnlyAdmission,
  input  wire              frameUntagged,
  input  wire              membershipCheck,
  input  wire              admitNonMember,
  input  wire              srcMember,
  input  wire              dstMember,
  input  wire              dstKnown,
  input  wire              dstUnicast,
  input  wire              dstMulticast,
  input  wire              dstBroadcast,
  input  wire              srcForwarding,
  input  wire              dstForwarding,
  input  wire              dropUnknownUnicast,
  input  wire              filterMulticast,
  input  wire              bcastOverLimit,
  input  wire              sameSrcDst,
  input  wire              entryFilter,
  input  wire              vlanAllOnes,
  // Interrupt side
  output wire              dropIrq,
  output wire              engineIrqMask
);

  // Handshake states, one-hot; an access is answered one cycle after
  // it is taken, so status is cleared by exactly one edge
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  // Drop reason codes; one table serves both capture sets
  localparam [3:0] CODE_TAGGED_ONLY     = 4'h0;
  localparam [3:0] CODE_UNK_SRC_MEMBER  = 4'h1;
  localparam [3:0] CODE_SRC_BLOCKED     = 4'h2;
  localparam [3:0] CODE_DST_BLOCKED     = 4'h3;
  localparam [3:0] CODE_DST_MEMBER      = 4'h4;
  localparam [3:0] CODE_SRC_MEMBER      = 4'h5;
  localparam [3:0] CODE_UNK_UNICAST     = 4'h6;
  localparam [3:0] CODE_UNK_MULTICAST   = 4'h7;
  localparam [3:0] CODE_BCAST_LIMIT     = 4'h8;
  localparam [3:0] CODE_UNK_SRC_BLOCKED = 4'h9;
  localparam [3:0] CODE_SAME_PORT       = 4'ha;
  localparam [3:0] CODE_ENTRY_FILTER    = 4'hb;
  localparam [3:0] CODE_VLAN_ALL_ONES   = 4'he;

  reg [1:0]  busState;
  reg [1:0]  next_busState;
  reg        maskBit;
  reg        next_maskBit;
  reg        pending;
  reg        next_pending;
  reg [31:0] next_readdata;
  reg [1:0]  next_response;
  reg [3:0]  reasonCode;
  reg        codeOk;

  // Capture set contents
  wire        validA;
  wire [1:0]  portA;
  wire [3:0]  reasonA;
  wire        validB;
  wire [1:0]  portB;
  wire [3:0]  reasonB;

  // Bus decode and capture qualifiers
  wire        reqActive;
  wire        hitStatus;
  wire        hitMask;
  wire        hitAny;
  wire        accept;
  wire        clrRead;
  wire        maskWrite;
  wire        capture;
  wire        takeA;
  wire        takeB;
  wire [14:0] statusWord;

  assign reqActive = read | write;
  assign hitStatus = (address == `SDEC_STATUS_ADDR);
  assign hitMask   = (address == `SDEC_MASK_ADDR);
  assign hitAny    = hitStatus | hitMask;
  assign accept    = reqActive & busState[0];
  assign clrRead   = accept & read & hitStatus;
  assign maskWrite = accept & write & hitMask & byteenable[0];

  // One wait cycle per access keeps the read-clear to a single edge
  assign waitrequest = reqActive & ~busState[1];

  // Illegal codes fall back to idle through the default branch
  always @* begin
    case (busState)
      ST_IDLE: begin
        next_busState = accept ? ST_ANSWER : ST_IDLE;
      end
      ST_ANSWER: begin
        next_busState = ST_IDLE;
      end
      default: begin
        next_busState = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busState <= ST_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // Priority order picks one code when several conditions hold at once
  always @* begin
    reasonCode = 4'h0;
    codeOk     = 1'b1;
    if (vlanAllOnes) begin
      reasonCode = CODE_VLAN_ALL_ONES;
    end else if (taggedOnlyAdmission & frameUntagged) begin
      reasonCode = CODE_TAGGED_ONLY;
    end else if (!dstKnown | dstBroadcast) begin
      if (!srcForwarding) begin
        reasonCode = CODE_UNK_SRC_BLOCKED;
      end else if (membershipCheck & ~admitNonMember & ~srcMember) begin
        reasonCode = CODE_UNK_SRC_MEMBER;
      end else if (dstBroadcast & bcastOverLimit) begin
        reasonCode = CODE_BCAST_LIMIT;
      end else if (dropUnknownUnicast & dstUnicast) begin
        reasonCode = CODE_UNK_UNICAST;
      end else if (filterMulticast & dstMulticast) begin
        reasonCode = CODE_UNK_MULTICAST;
      end else begin
        codeOk = 1'b0;
      end
    end else begin
      if (!srcForwarding) begin
        reasonCode = CODE_SRC_BLOCKED;
      end else if (!dstForwarding) begin
        reasonCode = CODE_DST_BLOCKED;
      end else if (membershipCheck & ~dstMember) begin
        reasonCode = CODE_DST_MEMBER;
      end else if (membershipCheck & ~admitNonMember & ~srcMember) begin
        reasonCode = CODE_SRC_MEMBER;
      end else if (entryFilter) begin
        reasonCode = CODE_ENTRY_FILTER;
      end else if (sameSrcDst) begin
        reasonCode = CODE_SAME_PORT;
      end else begin
        codeOk = 1'b0;
      end
    end
  end

  // A record is only meaningful with a known reason and a real port
  assign capture = dropEvent & codeOk & (dropPort != 2'h3);
  // A read-clear empties set A at once, so a drop in that same cycle
  // lands in A and set B is freed with it; B never stands without A
  assign takeA   = capture & (~validA | clrRead);
  assign takeB   = capture & validA & ~validB & ~clrRead;

  // Capture wins over a read-clear in the same cycle, so no event is lost
  always @* begin
    if (capture) begin
      next_pending = 1'b1;
    end else if (clrRead) begin
      next_pending = 1'b0;
    end else begin
      next_pending = pending;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  // Set A is filled first; set B only while A holds a record
  sdec_capture_set #(
    .PORT_W (2),
    .CODE_W (4)
  ) setA (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .take    (takeA),
    .clear   (clrRead),
    .portIn  (dropPort),
    .codeIn  (reasonCode),
    .valid   (validA),
    .port    (portA),
    .code    (reasonA)
  );

  sdec_capture_set #(
    .PORT_W (2),
    .CODE_W (4)
  ) setB (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .take    (takeB),
    .clear   (clrRead),
    .portIn  (dropPort),
    .codeIn  (reasonCode),
    .valid   (validB),
    .port    (portB),
    .code    (reasonB)
  );

  // Both sets kept side by side in one status word
  assign statusWord[`SDEC_PEND_BIT]          = pending;
  assign statusWord[`SDEC_AVALID_BIT]        = validA;
  assign statusWord[`SDEC_APORT_LO +: 2]     = portA;
  assign statusWord[`SDEC_AREASON_LO +: 4]   = reasonA;
  assign statusWord[`SDEC_BVALID_BIT]        = validB;
  assign statusWord[`SDEC_BPORT_LO +: 2]     = portB;
  assign statusWord[`SDEC_BREASON_LO +: 4]   = reasonB;

  // Only byte lane 0 carries the mask bit
  always @* begin
    if (maskWrite) begin
      next_maskBit = writedata[0];
    end else begin
      next_maskBit = maskBit;
    end
  end

  // Mask resets to one so nothing escapes before software is ready
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      maskBit <= `SDEC_MASK_RESET;
    end else begin
      maskBit <= next_maskBit;
    end
  end

  // Read data is formed at the edge that takes the access and stands
  // until the next accepted access; bits 31:15 always read as zero
  always @* begin
    next_readdata = readdata;
    next_response = response;
    if (accept) begin
      if (hitAny) begin
        next_response = 2'h0;
      end else begin
        next_response = 2'h3;
      end
      if (read & hitStatus) begin
        next_readdata = {17'h0, statusWord};
      end else if (read & hitMask) begin
        next_readdata = {31'h0, maskBit};
      end else begin
        next_readdata = `SDEC_UNMAPPED_DATA;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= `SDEC_UNMAPPED_DATA;
      response <= 2'h0;
    end else begin
      readdata <= next_readdata;
      response <= next_response;
    end
  end

  // The interrupt leaves the block only while unmasked
  assign dropIrq       = pending & ~maskBit;
  assign engineIrqMask = maskBit;

endmodule // sdec_drop_capture

// One capture set: a drop record that stands until software reads it.
// Driven by the status block above; take and clear may coincide.
module sdec_capture_set #(
  parameter PORT_W = 2,
  parameter CODE_W = 4
) (
  input  wire              ref_clk,
  input  wire              rst_b,
  input  wire              take,
  input  wire              clear,
  // Record presented with the drop pulse
  input  wire [PORT_W-1:0] portIn,
  input  wire [CODE_W-1:0] codeIn,
  // Stored record
  output reg               valid,
  output reg  [PORT_W-1:0] port,
  output reg  [CODE_W-1:0] code
);

  reg              next_valid;
  reg [PORT_W-1:0] next_port;
  reg [CODE_W-1:0] next_code;

  // Take beats clear, so a drop in the read cycle is kept
  always @* begin
    next_valid = valid;
    next_port  = port;
    next_code  = code;
    if (take) begin
      next_valid = 1'b1;
      next_port  = portIn;
      next_code  = codeIn;
    end else if (clear) begin
      next_valid = 1'b0;
      next_port  = {PORT_W{1'b0}};
      next_code  = {CODE_W{1'b0}};
    end
  end

  // A cleared record reads as all zero
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid <= 1'b0;
      port  <= {PORT_W{1'b0}};
      code  <= {CODE_W{1'b0}};
    end else begin
      valid <= next_valid;
      port  <= next_port;
      code  <= next_code;
    end
  end

endmodule // sdec_capture_set

/* rtl/sdec_map.vh */
// Register map and field layout of the switch drop event capture block.
// Included by the design; holds definitions only.
`ifndef SDEC_MAP_VH
`define SDEC_MAP_VH
// Printed register numbers are indices; byte address is four times index
`define SDEC_STATUS_IDX      14'h1881
`define SDEC_MASK_IDX        14'h1880
`define SDEC_STATUS_ADDR     16'h6204
`define SDEC_MASK_ADDR       16'h6200
`define SDEC_PEND_BIT        0
`define SDEC_AVALID_BIT      1
`define SDEC_APORT_LO        2
`define SDEC_AREASON_LO      4
`define SDEC_BVALID_BIT      8
`define SDEC_BPORT_LO        9
`define SDEC_BREASON_LO      11
`define SDEC_MASK_RESET      1'h1
`define SDEC_STATUS_RESET    15'h0000
`define SDEC_UNMAPPED_DATA   32'h00000000
`endif

/* test/sdec_drop_capture_properties.sv */
// Checker for the drop capture block, bound to its ports.
// Assumes status at 16'h6204, mask at 16'h6200, one wait cycle.
`timescale 1ns/10ps
module sdec_drop_capture_properties (
  input wire        ref_clk,
  input wire        rst_b,
  input wire [15:0] address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire        waitrequest,
  input wire [31:0] readdata,
  input wire [1:0]  response,
  input wire        dropEvent,
  input wire        dropIrq,
  input wire        engineIrqMask
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ack = (read | write) & !waitrequest;
  wire sRd = read & ack & (address == 16'h6204);
  wire bad = ack & (address != 16'h6204) & (address != 16'h6200);
  a_one_wait: assert property ((read | write) && waitrequest |=>
    !waitrequest) else $error("no answer after one wait");
  a_mask_blocks: assert property (dropIrq |-> !engineIrqMask)
    else $error("interrupt while masked");
  a_irq_cause: assert property ($rose(dropIrq) |->
    $past(dropEvent) || $past(write)) else $error("interrupt from nowhere");
  a_mask_write: assert property (write && ack && address == 16'h6200 &&
    byteenable[0] |=> engineIrqMask == $past(writedata[0]))
    else $error("mask write lost");
  a_mask_reset: assert property ($rose(rst_b) |-> engineIrqMask)
    else $error("mask not set after reset");
  a_unmapped_err: assert property (bad && read |->
    response == 2'h3 && readdata == 32'h0) else $error("unmapped read");
  a_reserved_zero: assert property (sRd |->
    readdata[31:15] == 17'h0 && response == 2'h0) else $error("bad status");
  a_b_after_a: assert property (sRd && readdata[8] |->
    readdata[1] && readdata[0]) else $error("set B without set A");
  a_port_legal: assert property (sRd && readdata[1] |->
    readdata[3:2] != 2'h3 && readdata[0]) else $error("bad port A");
  a_code_legal: assert property (sRd && readdata[1] |->
    !(readdata[7:4] inside {4'hc, 4'hd, 4'hf})) else $error("bad code");
  c_both_sets: cover property (sRd && readdata[8]);
  c_unmapped: cover property (bad && read);
  c_irq: cover property ($rose(dropIrq));
endmodule // sdec_drop_capture_properties
bind sdec_drop_capture sdec_drop_capture_properties u_prop (.*);

/* test/sdec_drop_capture_tb.sv */
// Bench for the drop capture block: bus reads, drop pulses, mask.
// Assumes the fixed register addresses and byte lanes all enabled.
`timescale 1ns/10ps
module sdec_drop_capture_tb;
  reg         ref_clk = 0;
  reg         rst_b = 0;
  reg  [15:0] address = 0;
  reg         read = 0;
  reg         write = 0;
  reg  [31:0] writedata = 0;
  reg         dropEvent = 0;
  reg  [1:0]  dropPort = 0;
  reg  [17:0] cond = 0;
  reg  [31:0] rd;
  reg  [31:0] e;
  reg  [1:0]  rsp;
  reg  [1:0]  pa = 0;
  reg  [1:0]  pb;
  wire        waitrequest;
  wire [31:0] readdata;
  wire [1:0]  response;
  wire        dropIrq;
  wire        engineIrqMask;
  integer     n_errors = 0;
  integer     n_tests = 0;
  integer     i;
  integer     j;
  // Entries are {expected code, condition vector}
  localparam logic [21:0] T [13] = '{22'h00c33, 22'h40c24, 22'h80870,
    22'hc0470, 22'h100c54, 22'h140c64, 22'h181cb0, 22'h1c2d30, 22'h204e30,
    22'h240a30, 22'h288c70, 22'h2d0c70, 22'h3a0c30};
  sdec_drop_capture uut (.*, .byteenable(4'hf),
    .taggedOnlyAdmission(cond[0]), .frameUntagged(cond[1]),
    .membershipCheck(cond[2]), .admitNonMember(cond[3]),
    .srcMember(cond[4]), .dstMember(cond[5]), .dstKnown(cond[6]),
    .dstUnicast(cond[7]), .dstMulticast(cond[8]), .dstBroadcast(cond[9]),
    .srcForwarding(cond[10]), .dstForwarding(cond[11]),
    .dropUnknownUnicast(cond[12]), .filterMulticast(cond[13]),
    .bcastOverLimit(cond[14]), .sameSrcDst(cond[15]),
    .entryFilter(cond[16]), .vlanAllOnes(cond[17]));
  initial forever #50 ref_clk = ~ref_clk;
  task end_of_test;
    begin
      $display("Tests %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [15:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      k = 0;
      // Waitrequest settles mid-cycle and stands until the next edge
      @(negedge ref_clk);
      while (waitrequest !== 1'b0 && k < 20) begin
        k = k + 1;
        @(negedge ref_clk);
      end
      @(posedge ref_clk);
      rd = readdata;
      rsp = response;
      read <= 0;
      write <= 0;
      if (k == 20) begin
        n_errors = n_errors + 1;
        end_of_test;
      end
    end
  endtask
  task drop(input [1:0] p, input [17:0] c);
    begin
      @(posedge ref_clk);
      dropEvent <= 1;
      dropPort <= p;
      cond <= c;
      @(posedge ref_clk);
      dropEvent <= 0;
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1;
    bus(0, 16'h6204, 0);
    chk(rd, 0);
    bus(0, 16'h6200, 0);
    chk(rd, 1);
    drop(1, T[0][17:0]);
    // Port code 11 must not occupy set B
    drop(3, T[1][17:0]);
    chk(dropIrq, 0);
    bus(1, 16'h6200, 0);
    @(negedge ref_clk);
    chk(dropIrq, 1);
    bus(0, 16'h6204, 0);
    chk(rd, 32'h7);
    @(negedge ref_clk);
    chk(dropIrq, 0);
    bus(0, 16'h6208, 0);
    chk(rsp, 2'h3);
    chk(rd, 0);
    bus(1, 16'h6208, 1);
    chk(engineIrqMask, 0);
    // Third drop of each round finds both sets full and must vanish
    for (i = 0; i < 13; i = i + 1) begin
      j = (i + 1) % 13;
      pb = 2'h2 - pa;
      drop(pa, T[i][17:0]);
      drop(pb, T[j][17:0]);
      drop(2'h0, T[(i + 2) % 13][17:0]);
      bus(0, 16'h6204, 0);
      e = {17'h0, T[j][21:18], pb, 1'b1, T[i][21:18], pa, 2'b11};
      chk(rd, e);
      bus(0, 16'h6204, 0);
      chk(rd, 0);
      pa = (pa == 2'h2) ? 2'h0 : pa + 2'h1;
    end
    end_of_test;
  end
endmodule // sdec_drop_capture_tb
